// >>> rtl/arsr_pkg.sv
// package: register map, field layout and reset values of the analog readout bank
package arsr_pkg;
    // printed offsets are not all multiples of four: these are indices, byte address = 4 * index
    localparam logic [7:0] REGULATOR_READOUT_IDX     = 8'h2c;
    localparam logic [7:0] SIGNAL_STRENGTH_PEAKS_IDX = 8'h2d;
    localparam logic [7:0] GAIN_REDUCTION_STATE_IDX  = 8'h2e;
    localparam logic [7:0] CAP_SENSOR_CONTROL_IDX    = 8'h2f;
    localparam logic [7:0] CAP_SENSOR_READOUT_IDX    = 8'h30;
    localparam logic [7:0] IRQ_STATUS_IDX            = 8'h40;
    localparam logic [7:0] IRQ_MASK_IDX              = 8'h41;
    localparam logic [7:0] ANALOG_COMMAND_IDX        = 8'h42;
    localparam int         BYTE_ADDR_W               = 10;

    // field positions
    localparam int REG_CODE_LSB   = 4;
    localparam int ILIM_BIT       = 0;
    localparam int AM_FIELD_LSB   = 4;
    localparam int PM_FIELD_LSB   = 0;
    localparam int TRIM_LSB       = 3;
    localparam int CAL_END_BIT    = 2;
    localparam int CAL_ERR_BIT    = 1;

    // interrupt status bits
    localparam int IRQ_REG_DONE   = 0;
    localparam int IRQ_ILIM       = 1;
    localparam int IRQ_CAL_END    = 2;
    localparam int IRQ_CAL_ERR    = 3;
    localparam int IRQ_W          = 4;

    // command bits (write-only pulses)
    localparam int CMD_CLEAR_STRENGTH = 0;
    localparam int CMD_ADJUST_REG     = 1;
    localparam int CMD_CALIBRATE      = 2;

    // reset values
    localparam logic [7:0]      CAP_CTRL_RESET  = 8'h00;
    localparam logic [3:0]      REG_CODE_RESET  = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    // sensor gain codes
    localparam logic [2:0] GAIN_2P8  = 3'h0;
    localparam logic [2:0] GAIN_6P5  = 3'h1;
    localparam logic [2:0] GAIN_1P1  = 3'h2;
    localparam logic [2:0] GAIN_0P5  = 3'h4;
    localparam logic [2:0] GAIN_0P35 = 3'h6;
endpackage : arsr_pkg

// >>> rtl/arsr_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module arsr_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : arsr_sync
`default_nettype wire

// >>> rtl/arsr_regs.sv
// analog readout and capacitive sensor register bank with apb slave and interrupt
// How it works
// - the upper nibble of the regulator readout shows the code picked by the last regulator adjust.
// - that code is a plain four-bit step code, 1111 highest and 0000 lowest, passed on unaltered.
// - bit 0 of the regulator readout follows the rf supply rail current-limit indication.
// - the am peak nibble is captured and held until a new reception starts or software clears it.
// - the pm peak nibble is captured and held under the same conditions as the am nibble.
// - peak codes rise with level, so holding the largest code seen keeps the true peak.
// - the upper nibble of the gain state shows the total am attenuation from the analog side.
// - the lower nibble of the gain state shows the total pm attenuation from the analog side.
// - the manual trim field sits in bits 7 to 3 of the control register, lsb weighing 0.1 pF.
// - an all-zero manual trim field selects automatic calibration.
// - the three-bit gain select drives the sensor gain; unused codes are passed but flagged.
// - bits 7 to 3 of the sensor readout show the trim value now in use.
// - bit 2 of the sensor readout is set once a calibration has finished.
// - bit 1 of the sensor readout is set when a calibration failed.
`timescale 1ns/1ns
`default_nettype none
module arsr_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog front end status (asynchronous)
    input  wire logic        regulator_adjust_done,
    input  wire logic [3:0]  regulator_adjust_code,
    input  wire logic        rf_supply_rail_current_limit,
    input  wire logic        reception_start,
    input  wire logic [3:0]  am_strength_level,
    input  wire logic [3:0]  pm_strength_level,
    input  wire logic [3:0]  am_total_attenuation,
    input  wire logic [3:0]  pm_total_attenuation,
    input  wire logic        capsense_cal_done,
    input  wire logic        capsense_cal_fail,
    input  wire logic [4:0]  capsense_auto_trim,
    // controls to the front end and interrupt request
    output logic             regulator_adjust_start,
    output logic             capsense_cal_start,
    output logic             capsense_auto_mode,
    output logic      [4:0]  capsense_manual_trim,
    output logic      [2:0]  capsense_gain_select,
    output logic             capsense_gain_unused,
    output logic             irq
);
    localparam int SYNC_W = 36;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_q;

    assign sync_in = {regulator_adjust_done, regulator_adjust_code,
                      rf_supply_rail_current_limit, reception_start,
                      am_strength_level, pm_strength_level,
                      am_total_attenuation, pm_total_attenuation,
                      capsense_cal_done, capsense_cal_fail, capsense_auto_trim, 6'h00};

    arsr_sync #(.W(SYNC_W)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (sync_in),
        .sync_out (sync_q)
    );

    logic       s_reg_done;
    logic [3:0] s_reg_code;
    logic       s_ilim;
    logic       s_rx_start;
    logic [3:0] s_am_lvl;
    logic [3:0] s_pm_lvl;
    logic [3:0] s_am_att;
    logic [3:0] s_pm_att;
    logic       s_cal_done;
    logic       s_cal_fail;
    logic [4:0] s_auto_trim;

    assign {s_reg_done, s_reg_code, s_ilim, s_rx_start, s_am_lvl, s_pm_lvl,
            s_am_att, s_pm_att, s_cal_done, s_cal_fail, s_auto_trim} = sync_q[SYNC_W-1:6];

    // edge detection on synchronised levels
    logic reg_done_d_reg;
    logic rx_start_d_reg;
    logic cal_done_d_reg;
    logic cal_fail_d_reg;
    logic ilim_d_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_done_d_reg <= 1'b0;
            rx_start_d_reg <= 1'b0;
            cal_done_d_reg <= 1'b0;
            cal_fail_d_reg <= 1'b0;
            ilim_d_reg     <= 1'b0;
        end else begin
            reg_done_d_reg <= s_reg_done;
            rx_start_d_reg <= s_rx_start;
            cal_done_d_reg <= s_cal_done;
            cal_fail_d_reg <= s_cal_fail;
            ilim_d_reg     <= s_ilim;
        end
    end

    logic reg_done_rise;
    logic rx_start_rise;
    logic cal_done_rise;
    logic cal_fail_rise;
    logic ilim_rise;

    assign reg_done_rise = s_reg_done & ~reg_done_d_reg;
    assign rx_start_rise = s_rx_start & ~rx_start_d_reg;
    assign cal_done_rise = s_cal_done & ~cal_done_d_reg;
    assign cal_fail_rise = s_cal_fail & ~cal_fail_d_reg;
    assign ilim_rise     = s_ilim & ~ilim_d_reg;

    // apb decode; zero wait states
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
    endfunction : hit

    logic setup;
    logic wr_acc;
    logic mapped;

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & pready;
    assign mapped = hit(paddr, arsr_pkg::REGULATOR_READOUT_IDX)
                  | hit(paddr, arsr_pkg::SIGNAL_STRENGTH_PEAKS_IDX)
                  | hit(paddr, arsr_pkg::GAIN_REDUCTION_STATE_IDX)
                  | hit(paddr, arsr_pkg::CAP_SENSOR_CONTROL_IDX)
                  | hit(paddr, arsr_pkg::CAP_SENSOR_READOUT_IDX)
                  | hit(paddr, arsr_pkg::IRQ_STATUS_IDX)
                  | hit(paddr, arsr_pkg::IRQ_MASK_IDX)
                  | hit(paddr, arsr_pkg::ANALOG_COMMAND_IDX);

    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic wr_cmd;

    assign wr_ctrl = wr_acc & pstrb[0] & hit(paddr, arsr_pkg::CAP_SENSOR_CONTROL_IDX);
    assign wr_stat = wr_acc & pstrb[0] & hit(paddr, arsr_pkg::IRQ_STATUS_IDX);
    assign wr_mask = wr_acc & pstrb[0] & hit(paddr, arsr_pkg::IRQ_MASK_IDX);
    assign wr_cmd  = wr_acc & pstrb[0] & hit(paddr, arsr_pkg::ANALOG_COMMAND_IDX);

    // pready rises in the cycle after setup: every access is two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
        end
    end

    logic [3:0] reg_code_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_code_reg <= arsr_pkg::REG_CODE_RESET;
        end else if (reg_done_rise) begin
            reg_code_reg <= s_reg_code;
        end
    end

    logic [3:0] am_peak_reg;
    logic [3:0] pm_peak_reg;
    logic       clr_strength;

    assign clr_strength = wr_cmd & pwdata[arsr_pkg::CMD_CLEAR_STRENGTH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            am_peak_reg <= 4'h0;
            pm_peak_reg <= 4'h0;
        end else if (clr_strength || rx_start_rise) begin
            // a new reception restarts the peak from the present sample
            am_peak_reg <= rx_start_rise ? s_am_lvl : 4'h0;
            pm_peak_reg <= rx_start_rise ? s_pm_lvl : 4'h0;
        end else begin
            if (s_am_lvl > am_peak_reg) begin
                am_peak_reg <= s_am_lvl;
            end
            if (s_pm_lvl > pm_peak_reg) begin
                pm_peak_reg <= s_pm_lvl;
            end
        end
    end

    logic [7:0] cap_ctrl_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_ctrl_reg <= arsr_pkg::CAP_CTRL_RESET;
        end else if (wr_ctrl) begin
            cap_ctrl_reg <= pwdata[7:0];
        end
    end

    function automatic logic gain_unused(input logic [2:0] g);
        gain_unused = !(g == arsr_pkg::GAIN_2P8 || g == arsr_pkg::GAIN_6P5
                     || g == arsr_pkg::GAIN_1P1 || g == arsr_pkg::GAIN_0P5
                     || g == arsr_pkg::GAIN_0P35);
    endfunction : gain_unused

    logic [4:0] manual_trim;
    logic       auto_mode;
    assign manual_trim = cap_ctrl_reg[7:arsr_pkg::TRIM_LSB];
    assign auto_mode   = (manual_trim == 5'h00);

    logic [4:0] trim_used_reg;
    logic       cal_end_reg;
    logic       cal_err_reg;
    logic       cal_go;

    assign cal_go = wr_cmd & pwdata[arsr_pkg::CMD_CALIBRATE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_used_reg <= 5'h00;
        end else begin
            trim_used_reg <= auto_mode ? s_auto_trim : manual_trim;
        end
    end

    // flags clear at a new calibration start; a finishing event in that cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_end_reg <= 1'b0;
            cal_err_reg <= 1'b0;
        end else begin
            if (cal_done_rise) begin
                cal_end_reg <= 1'b1;
            end else if (cal_go) begin
                cal_end_reg <= 1'b0;
            end
            if (cal_fail_rise) begin
                cal_err_reg <= 1'b1;
            end else if (cal_go) begin
                cal_err_reg <= 1'b0;
            end
        end
    end

    // command pulses and control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_adjust_start <= 1'b0;
            capsense_cal_start     <= 1'b0;
        end else begin
            regulator_adjust_start <= wr_cmd & pwdata[arsr_pkg::CMD_ADJUST_REG];
            capsense_cal_start     <= cal_go;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capsense_auto_mode   <= 1'b1;
            capsense_manual_trim <= 5'h00;
            capsense_gain_select <= arsr_pkg::GAIN_2P8;
            capsense_gain_unused <= 1'b0;
        end else begin
            capsense_auto_mode   <= auto_mode;
            capsense_manual_trim <= manual_trim;
            // gain select and unused code flag
            capsense_gain_select <= cap_ctrl_reg[2:0];
            capsense_gain_unused <= gain_unused(cap_ctrl_reg[2:0]);
        end
    end

    // interrupts: sticky, write one to clear, set wins
    logic [arsr_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [arsr_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [arsr_pkg::IRQ_W-1:0] irq_evt;

    assign irq_evt = {cal_fail_rise, cal_done_rise, ilim_rise, reg_done_rise};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= irq_evt
                          | (irq_stat_reg & ~(wr_stat ? pwdata[arsr_pkg::IRQ_W-1:0] : '0));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= arsr_pkg::IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_reg <= pwdata[arsr_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // read mux; readouts ignore writes, reserved bits are zero
    logic [31:0] rd_next;
    always_comb begin
        rd_next = 32'h0000_0000;
        if (hit(paddr, arsr_pkg::REGULATOR_READOUT_IDX)) begin
            rd_next[7:arsr_pkg::REG_CODE_LSB] = reg_code_reg;
            rd_next[arsr_pkg::ILIM_BIT]       = s_ilim;
        end else if (hit(paddr, arsr_pkg::SIGNAL_STRENGTH_PEAKS_IDX)) begin
            rd_next[7:arsr_pkg::AM_FIELD_LSB]   = am_peak_reg;
            rd_next[3:arsr_pkg::PM_FIELD_LSB]   = pm_peak_reg;
        end else if (hit(paddr, arsr_pkg::GAIN_REDUCTION_STATE_IDX)) begin
            rd_next[7:arsr_pkg::AM_FIELD_LSB]   = s_am_att;
            rd_next[3:arsr_pkg::PM_FIELD_LSB]   = s_pm_att;
        end else if (hit(paddr, arsr_pkg::CAP_SENSOR_CONTROL_IDX)) begin
            rd_next[7:0] = cap_ctrl_reg;
        end else if (hit(paddr, arsr_pkg::CAP_SENSOR_READOUT_IDX)) begin
            rd_next[7:arsr_pkg::TRIM_LSB]  = trim_used_reg;
            rd_next[arsr_pkg::CAL_END_BIT] = cal_end_reg;
            rd_next[arsr_pkg::CAL_ERR_BIT] = cal_err_reg;
        end else if (hit(paddr, arsr_pkg::IRQ_STATUS_IDX)) begin
            rd_next[arsr_pkg::IRQ_W-1:0] = irq_stat_reg;
        end else if (hit(paddr, arsr_pkg::IRQ_MASK_IDX)) begin
            rd_next[arsr_pkg::IRQ_W-1:0] = irq_mask_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_next;
        end else if (pready) begin
            // data stands only for the access cycle
            prdata <= 32'h0000_0000;
        end
    end
endmodule : arsr_regs
`default_nettype wire

// >>> tb/arsr_regs_checker.sv
// checker: bus timing and control-output relations of the analog readout bank
`timescale 1ns/1ns
`default_nettype none
module arsr_regs_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        regulator_adjust_start,
    input wire logic        capsense_cal_start,
    input wire logic        capsense_auto_mode,
    input wire logic [4:0]  capsense_manual_trim,
    input wire logic [2:0]  capsense_gain_select,
    input wire logic        capsense_gain_unused
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr_acc;
    assign wr_acc = psel && penable && pready && pwrite && pstrb[0];

    a_setup_answered: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0000_00)
        else $error("upper read bits not zero");
    a_misalign_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_reserved_zero: assert property (pready && !pwrite && paddr == 12'h0b0 |-> prdata[3:1] == 3'h0)
        else $error("reserved regulator bits set");
    a_trim_write: assert property (wr_acc && paddr == 12'h0bc |=> ##1 capsense_manual_trim == $past(pwdata[7:3], 2))
        else $error("manual trim not taken from write");
    a_auto_mode: assert property ($stable(capsense_manual_trim) |-> capsense_auto_mode == (capsense_manual_trim == 5'h00))
        else $error("auto mode does not follow zero trim");
    a_gain_unused: assert property ($stable(capsense_gain_select) |-> capsense_gain_unused == !(capsense_gain_select inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6}))
        else $error("unused gain flag wrong");
    a_adjust_cause: assert property (wr_acc && paddr == 12'h108 && pwdata[1] |=> regulator_adjust_start)
        else $error("adjust command gave no pulse");
    a_adjust_pulse: assert property (regulator_adjust_start |=> !regulator_adjust_start)
        else $error("adjust pulse too long");
    a_cal_cause: assert property (wr_acc && paddr == 12'h108 && pwdata[2] |=> capsense_cal_start ##1 !capsense_cal_start)
        else $error("calibrate command pulse wrong");
endmodule : arsr_regs_checker

bind arsr_regs arsr_regs_checker arsr_regs_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .regulator_adjust_start(regulator_adjust_start), .capsense_cal_start(capsense_cal_start),
    .capsense_auto_mode(capsense_auto_mode), .capsense_manual_trim(capsense_manual_trim),
    .capsense_gain_select(capsense_gain_select), .capsense_gain_unused(capsense_gain_unused));
`default_nettype wire

// >>> tb/tb_analog_readout_status_regs.sv
// testbench: register table, readout, command and interrupt checks of the readout bank
`timescale 1ns/1ns
`default_nettype none
module tb_analog_readout_status_regs;
    typedef struct packed {logic [7:0] w; logic [7:0] ro; logic am; logic un;} arsr_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb, adj_code, am_lvl, pm_lvl, am_att, pm_att;
    logic        adj_done, ilim, rx_start, cal_done, cal_fail, adj_go, cal_go, auto_m, unused;
    logic [4:0]  auto_trim, man_trim;
    logic [2:0]  gain_sel;
    int          bad_count, compares;
    // trim 0 must show the automatic trim 10101 in bits 7:3
    arsr_row_t rows [8] = '{'{8'h00, 8'ha8, 1'b1, 1'b0}, '{8'h09, 8'h08, 1'b0, 1'b0},
        '{8'h12, 8'h10, 1'b0, 1'b0}, '{8'h1b, 8'h18, 1'b0, 1'b1}, '{8'h84, 8'h80, 1'b0, 1'b0},
        '{8'hf5, 8'hf0, 1'b0, 1'b1}, '{8'hfe, 8'hf8, 1'b0, 1'b0}, '{8'h07, 8'ha8, 1'b1, 1'b1}};

    arsr_regs arsr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .regulator_adjust_done(adj_done),
        .regulator_adjust_code(adj_code), .rf_supply_rail_current_limit(ilim),
        .reception_start(rx_start), .am_strength_level(am_lvl), .pm_strength_level(pm_lvl),
        .am_total_attenuation(am_att), .pm_total_attenuation(pm_att),
        .capsense_cal_done(cal_done), .capsense_cal_fail(cal_fail),
        .capsense_auto_trim(auto_trim), .regulator_adjust_start(adj_go),
        .capsense_cal_start(cal_go), .capsense_auto_mode(auto_m),
        .capsense_manual_trim(man_trim), .capsense_gain_select(gain_sel),
        .capsense_gain_unused(unused), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // request held until pready is sampled high, released only after that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0000_00, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            summarize();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, 4'h0);
        chk(rdat, {24'h0000_00, e});
    endtask : rd

    // asynchronous inputs need two edges to be seen, one more for the register
    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask : idle

    initial begin
        {presetn, psel, penable, pwrite, adj_done, ilim, rx_start, cal_done, cal_fail} = '0;
        {paddr, pwdata, pstrb, adj_code, am_lvl, pm_lvl, am_att, pm_att, auto_trim} = '0;
        idle(5);
        presetn <= 1'b1;
        rd(12'h0bc, 8'h00);
        rd(12'h104, 8'h00);
        rd(12'h100, 8'h00);
        rd(12'h0b4, 8'h00);
        auto_trim <= 5'h15;
        foreach (rows[i]) begin
            wr(12'h0bc, rows[i].w);
            rd(12'h0bc, rows[i].w);
            chk(32'(auto_m), 32'(rows[i].am));
            chk(32'(unused), 32'(rows[i].un));
            chk(32'({man_trim, gain_sel}), 32'(rows[i].w));
            rd(12'h0c0, rows[i].ro);
        end
        adj_code <= 4'hf;
        adj_done <= 1'b1;
        idle(5);
        rd(12'h0b0, 8'hf0);
        adj_done <= 1'b0;
        adj_code <= 4'h6;
        idle(5);
        adj_done <= 1'b1;
        ilim <= 1'b1;
        idle(5);
        rd(12'h0b0, 8'h61);
        rd(12'h100, 8'h03);
        chk(32'(irq), 32'h0000_0000);
        wr(12'h104, 8'h0f);
        idle(3);
        chk(32'(irq), 32'h0000_0001);
        wr(12'h100, 8'h03);
        idle(3);
        chk(32'(irq), 32'h0000_0000);
        wr(12'h108, 8'h02);
        // the pulse launched at the access edge still reads high at the next edge
        @(posedge pclk);
        chk(32'(adj_go), 32'h0000_0001);
        am_lvl <= 4'h3;
        pm_lvl <= 4'h5;
        rx_start <= 1'b1;
        idle(6);
        rd(12'h0b4, 8'h35);
        am_lvl <= 4'h7;
        pm_lvl <= 4'h2;
        idle(6);
        rd(12'h0b4, 8'h75);
        am_lvl <= 4'h2;
        pm_lvl <= 4'h1;
        rx_start <= 1'b0;
        idle(6);
        rd(12'h0b4, 8'h75);
        rx_start <= 1'b1;
        idle(6);
        rd(12'h0b4, 8'h21);
        {am_lvl, pm_lvl} <= 8'h00;
        idle(6);
        wr(12'h108, 8'h01);
        rd(12'h0b4, 8'h00);
        am_att <= 4'ha;
        pm_att <= 4'h3;
        idle(6);
        rd(12'h0b8, 8'ha3);
        wr(12'h0b8, 8'hff);
        rd(12'h0b8, 8'ha3);
        cal_done <= 1'b1;
        idle(6);
        rd(12'h0c0, 8'hac);
        cal_fail <= 1'b1;
        idle(6);
        rd(12'h0c0, 8'hae);
        rd(12'h100, 8'h0c);
        chk(32'(irq), 32'h0000_0001);
        {cal_done, cal_fail} <= 2'b00;
        idle(6);
        wr(12'h108, 8'h04);
        @(posedge pclk);
        chk(32'(cal_go), 32'h0000_0001);
        rd(12'h0c0, 8'ha8);
        wr(12'h100, 8'h0c);
        idle(3);
        chk(32'(irq), 32'h0000_0000);
        wr(12'h0c0, 8'hff);
        rd(12'h0c0, 8'ha8);
        apb(1'b1, 12'h0bc, 8'h55, 4'h0);
        rd(12'h0bc, 8'h07);
        rd(12'h200, 8'h00);
        chk(32'(rerr), 32'h0000_0001);
        rd(12'h0bd, 8'h00);
        chk(32'(rerr), 32'h0000_0001);
        // mid-run reset: control outputs return to automatic mode, gain code zero
        presetn <= 1'b0;
        idle(2);
        chk(32'({auto_m, irq, man_trim, gain_sel}), 32'h0000_0200);
        presetn <= 1'b1;
        rd(12'h0bc, 8'h00);
        rd(12'h0c0, 8'ha8);
        summarize();
    end
endmodule : tb_analog_readout_status_regs
`default_nettype wire
